// File: hw/bsnp_pkg.sv
// Constants, types and decode shared by the bus snoop and protocol-option logic.
// Assumes a single bus clock; transfer type codes are local encodings.
package bsnp_pkg;

	// ==========================================================
	// Register map (byte addresses, 32-bit words)
	localparam logic [7:0] BSNP_CTRL_OFF = 8'h00;
	localparam logic [7:0] BSNP_STATUS_OFF = 8'h04;
	localparam logic [7:0] BSNP_RETRY_OFF = 8'h08;

	// Control fields
	localparam int BSNP_CTRL_SNOOP_EN_BIT = 0;
	localparam logic BSNP_CTRL_SNOOP_EN_RST = 1'b1;

	// Status fields
	localparam int BSNP_ST_DRTRY_DIS_BIT = 0;
	localparam int BSNP_ST_STREAM_BIT = 1;
	localparam int BSNP_ST_WB_ACT_BIT = 2;
	localparam int BSNP_ST_IN_TEN_BIT = 3;
	localparam int BSNP_ST_OWN_TEN_BIT = 4;
	localparam int BSNP_ST_DTEN_BIT = 5;

	// ==========================================================
	// Bus geometry
	localparam int BSNP_TT_W = 5;
	localparam int BSNP_DATA_W = 32;
	localparam int BSNP_CTL_W = 10;
	localparam int BSNP_PIN_W = BSNP_CTL_W + BSNP_TT_W + BSNP_DATA_W;
	localparam logic [1:0] BSNP_LAST_BEAT = 2'h3;
	localparam logic [BSNP_PIN_W-1:0] BSNP_PIN_RST = {{BSNP_CTL_W{1'b1}}, {(BSNP_PIN_W-BSNP_CTL_W){1'b0}}};

	// Transfer type encodings
	localparam logic [BSNP_TT_W-1:0] BSNP_TT_SYNC = 5'h01;
	localparam logic [BSNP_TT_W-1:0] BSNP_TT_TLBSYNC = 5'h02;
	localparam logic [BSNP_TT_W-1:0] BSNP_TT_TLBIE = 5'h03;
	localparam logic [BSNP_TT_W-1:0] BSNP_TT_RWNITC = 5'h04;
	localparam logic [BSNP_TT_W-1:0] BSNP_TT_EIEIO = 5'h05;

	// ==========================================================
	// Snoop classes and data tenure states
	typedef enum logic [2:0] {
		BSNP_CLS_DATA,
		BSNP_CLS_RWNITC,
		BSNP_CLS_SYNC,
		BSNP_CLS_TLBSYNC,
		BSNP_CLS_TLBIE,
		BSNP_CLS_OTHER
	} bsnp_cls_t;

	typedef enum logic [1:0] {
		BSNP_DT_IDLE,
		BSNP_DT_BUSY,
		BSNP_DT_GAP
	} bsnp_dt_t;

	function automatic bsnp_cls_t bsnp_tt_class(input logic [BSNP_TT_W-1:0] tt);
		case (tt)
			BSNP_TT_SYNC: bsnp_tt_class = BSNP_CLS_SYNC;
			BSNP_TT_TLBSYNC: bsnp_tt_class = BSNP_CLS_TLBSYNC;
			BSNP_TT_TLBIE: bsnp_tt_class = BSNP_CLS_TLBIE;
			BSNP_TT_RWNITC: bsnp_tt_class = BSNP_CLS_RWNITC;
			BSNP_TT_EIEIO: bsnp_tt_class = BSNP_CLS_OTHER;
			default: bsnp_tt_class = BSNP_CLS_DATA;
		endcase
	endfunction : bsnp_tt_class

	// Classes whose snoop could lead to a writeback
	function automatic logic bsnp_may_wb(input bsnp_cls_t c);
		bsnp_may_wb = (c == BSNP_CLS_DATA) || (c == BSNP_CLS_RWNITC);
	endfunction : bsnp_may_wb

endpackage : bsnp_pkg

// File: hw/bsnp_sync.sv
// Two-stage synchroniser for a vector of pin inputs.
// Assumes each bit is sampled independently; the first stage is read by nothing else.
`timescale 1ns/100ps

module bsnp_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Data
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);

	logic [W-1:0] meta_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= RST_VAL;
			dout <= RST_VAL;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end

endmodule : bsnp_sync

// File: hw/bsnp_top.sv
// Snoop, address retry and bus protocol options of a processor bus interface, with an APB register port.
// Assumes bus pins are asynchronous to pclk and active low; core-side inputs are on pclk.
`timescale 1ns/100ps

module bsnp_top
	import bsnp_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Bus pins in
	input wire logic ts_n,
	input wire logic aack_n,
	input wire logic gbl_n,
	input wire logic [BSNP_TT_W-1:0] tt,
	input wire logic abb_n,
	input wire logic dbb_n,
	input wire logic bg_n,
	input wire logic dbg_n,
	input wire logic ta_n,
	input wire logic drtry_n,
	input wire logic hard_reset_pin_n,
	input wire logic [BSNP_DATA_W-1:0] dbus,
	// Bus pins out (open drain: value, enable)
	output logic ts_n_o,
	output logic ts_oe,
	output logic abb_n_o,
	output logic abb_oe,
	output logic artry_n_o,
	output logic artry_oe,
	output logic shd_n_o,
	output logic shd_oe,
	// Core: address and data requests
	input wire logic own_addr_req,
	input wire logic own_rd_req,
	output logic own_launch,
	output logic rd_valid,
	output logic [BSNP_DATA_W-1:0] rd_data,
	// Core: snoop lookup
	output logic snp_req,
	output logic [BSNP_TT_W-1:0] snp_tt,
	input wire logic lk_valid,
	input wire logic lk_hit_mod,
	input wire logic lk_hit_shr,
	output logic wb_req,
	input wire logic wb_done,
	output logic to_excl,
	output logic tlbie_evt,
	input wire logic stale_xlate_pend,
	input wire logic translation_wait_bit
);

	// ==========================================================
	// Pin synchronisation
	logic [BSNP_PIN_W-1:0] pin_s;
	logic s_ts, s_aack, s_gbl, s_abb, s_dbb, s_bg, s_dbg, s_ta, s_drtry, s_hard_reset_pin;
	logic [BSNP_TT_W-1:0] s_tt;
	logic [BSNP_DATA_W-1:0] s_data;

	bsnp_sync #(.W(BSNP_PIN_W), .RST_VAL(BSNP_PIN_RST)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.din({ts_n, aack_n, gbl_n, abb_n, dbb_n, bg_n, dbg_n, ta_n, drtry_n, hard_reset_pin_n, tt, dbus}),
		.dout(pin_s)
	);

	assign {s_ts, s_aack, s_gbl, s_abb, s_dbb, s_bg, s_dbg, s_ta, s_drtry, s_hard_reset_pin} =
		~pin_s[BSNP_PIN_W-1 -: BSNP_CTL_W];
	assign s_tt = pin_s[BSNP_DATA_W +: BSNP_TT_W];
	assign s_data = pin_s[BSNP_DATA_W-1:0];

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ==========================================================
	// Register state
	logic snoop_en_q, drtry_dis_q, stream_q;
	logic [31:0] retry_cnt_q;

	// Modes caught while hard reset is held
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drtry_dis_q <= 1'b0;
			stream_q <= 1'b0;
		end else if (s_hard_reset_pin) begin
			drtry_dis_q <= s_drtry;
			stream_q <= s_drtry;
		end
	end

	mode_latch_a: assert property (s_hard_reset_pin |=> drtry_dis_q == $past(s_drtry) && stream_q == $past(s_drtry))
		else $error("reset mode latch wrong");

	// ==========================================================
	// Address tenure tracking and own tenures
	logic in_ten_q, own_ten_q, ts_q, abb_q, own_d1_q, own_d2_q;
	logic launch;

	assign launch = own_addr_req && s_bg && !s_abb && !in_ten_q && !own_ten_q && !ts_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_ten_q <= 1'b0;
		end else if (s_ts) begin
			in_ten_q <= !s_aack;
		end else if (s_aack) begin
			in_ten_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ts_q <= 1'b0;
			abb_q <= 1'b0;
			own_ten_q <= 1'b0;
			own_d1_q <= 1'b0;
			own_d2_q <= 1'b0;
		end else begin
			ts_q <= launch;
			own_d1_q <= ts_q;
			own_d2_q <= own_d1_q;
			if (launch) begin
				own_ten_q <= 1'b1;
				abb_q <= 1'b1;
			end else if (own_ten_q && s_aack && !own_d2_q && !in_ten_q && !s_ts) begin
				own_ten_q <= 1'b0;
				abb_q <= 1'b0;
			end else if (own_ten_q && s_aack && !s_ts) begin
				own_ten_q <= 1'b0;
				abb_q <= 1'b0;
			end
		end
	end

	assign ts_n_o = !ts_q;
	assign ts_oe = ts_q;
	assign abb_n_o = !abb_q;
	assign abb_oe = abb_q;
	assign own_launch = ts_q;

	abb_grant_a: assert property (s_abb |=> !ts_q)
		else $error("address grant used while bus busy");
	abb_own_a: assert property (ts_q |-> abb_q)
		else $error("own tenure without address busy");

	// ==========================================================
	// Snoop capture and lookup
	logic snp_pend_q, snp_req_q, lk_done_q, lk_mod_q, lk_shr_q;
	logic [BSNP_TT_W-1:0] snp_tt_q;
	bsnp_cls_t cls;
	logic retry;
	logic wb_act_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			snp_pend_q <= 1'b0;
			snp_req_q <= 1'b0;
			snp_tt_q <= '0;
		end else begin
			snp_req_q <= 1'b0;
			if (s_ts && s_gbl && !own_d2_q && snoop_en_q) begin
				snp_pend_q <= 1'b1;
				snp_req_q <= 1'b1;
				snp_tt_q <= s_tt;
			end else if (s_aack) begin
				snp_pend_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lk_done_q <= 1'b0;
			lk_mod_q <= 1'b0;
			lk_shr_q <= 1'b0;
		end else if (snp_req_q) begin
			lk_done_q <= lk_valid;
			lk_mod_q <= lk_valid && lk_hit_mod;
			lk_shr_q <= lk_valid && lk_hit_shr;
		end else if (lk_valid && snp_pend_q && !lk_done_q) begin
			lk_done_q <= 1'b1;
			lk_mod_q <= lk_hit_mod;
			lk_shr_q <= lk_hit_shr;
		end
	end

	assign snp_req = snp_req_q;
	assign snp_tt = snp_tt_q;
	assign cls = bsnp_tt_class(snp_tt_q);

	always_comb begin
		retry = 1'b0;
		if (!lk_done_q && bsnp_may_wb(cls))
			retry = 1'b1;
		if (lk_mod_q && bsnp_may_wb(cls))
			retry = 1'b1;
		if (wb_act_q && bsnp_may_wb(cls))
			retry = 1'b1;
		if (wb_act_q && cls == BSNP_CLS_SYNC)
			retry = 1'b1;
		if (stale_xlate_pend && cls == BSNP_CLS_TLBSYNC)
			retry = 1'b1;
		if (translation_wait_bit && cls == BSNP_CLS_TLBIE)
			retry = 1'b1;
	end

	gbl_ignore_a: assert property (s_ts && !s_gbl |=> !snp_req_q)
		else $error("non-global transaction snooped");
	own_snoop_a: assert property (s_ts && own_d2_q |=> !snp_req_q)
		else $error("own transaction snooped");

	// ==========================================================
	// Responses in the retry window, writeback and side events
	logic artry_q, shd_q, wb_req_q, excl_q, tlbie_q;
	logic resp;

	assign resp = s_aack && snp_pend_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			artry_q <= 1'b0;
			shd_q <= 1'b0;
			wb_req_q <= 1'b0;
			excl_q <= 1'b0;
			tlbie_q <= 1'b0;
		end else begin
			artry_q <= resp && retry;
			shd_q <= resp && (lk_shr_q || lk_mod_q);
			wb_req_q <= resp && lk_mod_q && bsnp_may_wb(cls) && !wb_act_q;
			excl_q <= resp && !retry && lk_done_q && cls == BSNP_CLS_RWNITC;
			tlbie_q <= resp && !retry && cls == BSNP_CLS_TLBIE;
		end
	end

	// Writeback busy: new start wins over the done strobe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wb_act_q <= 1'b0;
		end else if (resp && lk_mod_q && bsnp_may_wb(cls)) begin
			wb_act_q <= 1'b1;
		end else if (wb_done) begin
			wb_act_q <= 1'b0;
		end
	end

	assign artry_n_o = !artry_q;
	assign artry_oe = artry_q;
	assign shd_n_o = !shd_q;
	assign shd_oe = shd_q;
	assign wb_req = wb_req_q;
	assign to_excl = excl_q;
	assign tlbie_evt = tlbie_q;

	sequence snoop_answered;
		resp ##0 lk_done_q;
	endsequence

	resp_window_a: assert property (artry_q || shd_q |-> $past(resp))
		else $error("response outside retry window");
	mod_hit_a: assert property (snoop_answered ##0 lk_mod_q && cls == BSNP_CLS_DATA
		|=> artry_q && wb_act_q)
		else $error("modified hit not retried or written back");
	wb_busy_a: assert property (resp && wb_act_q && bsnp_may_wb(cls) |=> artry_q)
		else $error("snoop during writeback not retried");
	sync_retry_a: assert property (resp && wb_act_q && cls == BSNP_CLS_SYNC |=> artry_q)
		else $error("sync during writeback not retried");
	tlbsync_retry_a: assert property (resp && stale_xlate_pend && cls == BSNP_CLS_TLBSYNC |=> artry_q)
		else $error("tlbsync with stale translation not retried");
	tlbie_wait_a: assert property (resp && translation_wait_bit && cls == BSNP_CLS_TLBIE |=> artry_q)
		else $error("tlb invalidate under translation wait not retried");
	late_tag_a: assert property (resp && !lk_done_q && cls == BSNP_CLS_DATA |=> artry_q)
		else $error("late tag lookup not retried");
	nitc_excl_a: assert property (snoop_answered ##0 !retry && cls == BSNP_CLS_RWNITC
		|=> to_excl ##1 !to_excl)
		else $error("non-caching read snoop did not go exclusive");

	// ==========================================================
	// Data tenures and read data
	bsnp_dt_t dt_q;
	logic [1:0] beat_q;
	logic hold_v_q, rd_v_q, commit, last, take;
	logic [BSNP_DATA_W-1:0] hold_q, rd_q;

	assign commit = drtry_dis_q ? (s_ta && dt_q == BSNP_DT_BUSY) : (hold_v_q && !s_drtry);
	assign last = commit && beat_q == BSNP_LAST_BEAT;
	assign take = own_rd_req && s_dbg && !s_dbb && (dt_q == BSNP_DT_IDLE || (stream_q && last));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dt_q <= BSNP_DT_IDLE;
			beat_q <= '0;
		end else begin
			if (commit)
				beat_q <= beat_q + 2'h1;
			case (dt_q)
				BSNP_DT_IDLE: if (take) dt_q <= BSNP_DT_BUSY;
				BSNP_DT_BUSY: if (last) dt_q <= take ? BSNP_DT_BUSY : (stream_q ? BSNP_DT_IDLE : BSNP_DT_GAP);
				BSNP_DT_GAP: dt_q <= BSNP_DT_IDLE;
				default: dt_q <= BSNP_DT_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_v_q <= 1'b0;
			hold_q <= '0;
			rd_v_q <= 1'b0;
			rd_q <= '0;
		end else begin
			hold_v_q <= !drtry_dis_q && s_ta && dt_q == BSNP_DT_BUSY;
			hold_q <= s_data;
			rd_v_q <= commit;
			rd_q <= drtry_dis_q ? s_data : hold_q;
		end
	end

	assign rd_valid = rd_v_q;
	assign rd_data = rd_q;

	sequence held_beat;
		!drtry_dis_q && s_ta && dt_q == BSNP_DT_BUSY ##1 !s_drtry;
	endsequence

	beat_delay_a: assert property (held_beat |=> rd_v_q)
		else $error("held beat not delivered");
	beat_cancel_a: assert property (hold_v_q && s_drtry |=> !rd_v_q)
		else $error("cancelled beat delivered");
	dbb_honour_a: assert property (s_dbb && dt_q != BSNP_DT_BUSY |=> dt_q != BSNP_DT_BUSY)
		else $error("data grant used while data bus busy");

	// ==========================================================
	// APB slave: zero wait states, data set up in the setup phase
	logic [31:0] rdata_q;
	logic err_q, ready_q, hit;

	assign hit = paddr == BSNP_CTRL_OFF || paddr == BSNP_STATUS_OFF || paddr == BSNP_RETRY_OFF;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= '0;
			err_q <= 1'b0;
			ready_q <= 1'b0;
		end else begin
			ready_q <= 1'b1;
			err_q <= psel && !penable && !hit;
			if (psel && !penable) begin
				case (paddr)
					BSNP_CTRL_OFF: rdata_q <= 32'({snoop_en_q} << BSNP_CTRL_SNOOP_EN_BIT);
					BSNP_STATUS_OFF: rdata_q <= 32'(({31'h0000_0000, drtry_dis_q} << BSNP_ST_DRTRY_DIS_BIT)
						| ({31'h0000_0000, stream_q} << BSNP_ST_STREAM_BIT)
						| ({31'h0000_0000, wb_act_q} << BSNP_ST_WB_ACT_BIT)
						| ({31'h0000_0000, in_ten_q} << BSNP_ST_IN_TEN_BIT)
						| ({31'h0000_0000, own_ten_q} << BSNP_ST_OWN_TEN_BIT)
						| ({31'h0000_0000, dt_q != BSNP_DT_IDLE} << BSNP_ST_DTEN_BIT));
					BSNP_RETRY_OFF: rdata_q <= retry_cnt_q;
					default: rdata_q <= '0;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			snoop_en_q <= BSNP_CTRL_SNOOP_EN_RST;
		end else if (psel && penable && pwrite && paddr == BSNP_CTRL_OFF) begin
			snoop_en_q <= pwdata[BSNP_CTRL_SNOOP_EN_BIT];
		end
	end

	// Retry counter: a write clears it, a retry in the same cycle still counts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			retry_cnt_q <= '0;
		end else if (psel && penable && pwrite && paddr == BSNP_RETRY_OFF) begin
			retry_cnt_q <= {31'h0000_0000, artry_q};
		end else if (artry_q) begin
			retry_cnt_q <= retry_cnt_q + 32'h0000_0001;
		end
	end

	assign prdata = rdata_q;
	assign pready = ready_q;
	assign pslverr = err_q;

endmodule : bsnp_top

// File: tb/bsnp_bus_agent.sv
// Bus agent model: arbiter, memory controller and a second snooping master.
// Assumes active-low pins on pclk; merges the block's ts_oe and abb_oe enables into the shared lines.
`timescale 1ns/100ps

module bsnp_bus_agent
	import bsnp_pkg::*;
(
	// Clock
	input wire logic pclk,
	// Block drive enables
	input wire logic ts_oe,
	input wire logic abb_oe,
	// Shared lines
	output logic ts_n,
	output logic aack_n,
	output logic abb_n,
	// Agent pins
	output logic gbl_n,
	output logic [BSNP_TT_W-1:0] tt,
	output logic dbb_n,
	output logic bg_n,
	output logic dbg_n,
	output logic ta_n,
	output logic drtry_n,
	output logic hard_reset_pin_n,
	output logic [BSNP_DATA_W-1:0] dbus
);
	logic m_ts_n = 1'b1;
	logic m_aack_n = 1'b1;
	logic m_abb_n = 1'b1;
	logic own_ack = 1'b0;
	int own_cnt = 0;

	// ==========================================================
	// Shared lines
	assign ts_n = m_ts_n & ~ts_oe;
	assign abb_n = m_abb_n & ~abb_oe;
	assign aack_n = m_aack_n & ~own_ack;

	initial begin
		{gbl_n, dbb_n, dbg_n, ta_n, drtry_n, hard_reset_pin_n} = '1;
		bg_n = 1'b0;
		tt = '0;
		dbus = '0;
	end

	// Acknowledge the block's own address tenure
	always @(posedge pclk) begin
		own_ack <= (own_cnt == 1);
		if (ts_oe === 1'b1)
			own_cnt <= 3;
		else if (own_cnt > 0)
			own_cnt <= own_cnt - 1;
	end

	// ==========================================================
	// Address tenure from another master, without address busy
	task automatic snoop(input logic g, input logic [BSNP_TT_W-1:0] t, input int dly);
		@(posedge pclk);
		m_ts_n <= 1'b0;
		gbl_n <= ~g;
		tt <= t;
		@(posedge pclk);
		m_ts_n <= 1'b1;
		repeat (dly) @(posedge pclk);
		m_aack_n <= 1'b0;
		@(posedge pclk);
		m_aack_n <= 1'b1;
		gbl_n <= 1'b1;
		tt <= ~t;
	endtask : snoop

	// ==========================================================
	// Read bursts; grant in the cycle before the first beat and in the last beat of each burst but the final one
	// A beat cancelled by data retry costs one extra beat at the end
	task automatic burst(input int n, input logic [31:0] base, input int kill);
		int nb = 4 * n + int'(kill < 4 * n);
		@(posedge pclk);
		dbg_n <= 1'b0;
		for (int i = 0; i < nb; i++) begin
			@(posedge pclk);
			ta_n <= 1'b0;
			dbus <= base + 32'(i);
			dbg_n <= !(i % 4 == 3 && i < 4 * n - 1);
			drtry_n <= (i != kill + 1);
		end
		@(posedge pclk);
		ta_n <= 1'b1;
		dbus <= ~dbus;
		drtry_n <= (nb != kill + 1);
		@(posedge pclk);
		drtry_n <= 1'b1;
	endtask : burst

endmodule : bsnp_bus_agent

// File: tb/tb.sv
// Self-checking bench for the bus snoop and protocol-option block.
// Assumes the agent model drives the bus pins; the bench plays the core and the APB master.
`timescale 1ns/100ps

module tb
	import bsnp_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic ts_n, aack_n, gbl_n, abb_n, dbb_n, bg_n, dbg_n, ta_n, drtry_n, hard_reset_pin_n;
	logic [BSNP_TT_W-1:0] tt, snp_tt;
	logic [BSNP_DATA_W-1:0] dbus, rd_data;
	logic ts_oe, abb_oe, artry_oe, shd_oe, own_launch, rd_valid, snp_req, wb_req, to_excl, tlbie_evt;
	logic own_addr_req, own_rd_req, lk_valid, lk_hit_mod, lk_hit_shr, wb_done, stale_xlate_pend;
	logic translation_wait_bit, er;
	int error_cnt = 0, tests_run = 0, cyc = 0, t_aack, t_art, t_ta, t_rv, t_rvl;
	int cnt[9];
	logic [31:0] rdq[$];
	wire [8:0] ev = {abb_oe, own_launch, rd_valid, tlbie_evt, to_excl, wb_req, shd_oe, artry_oe, snp_req};

	bsnp_top i_bsnp_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .ts_n, .aack_n, .gbl_n, .tt, .abb_n, .dbb_n, .bg_n, .dbg_n, .ta_n, .drtry_n,
		.hard_reset_pin_n, .dbus, .ts_n_o(), .ts_oe, .abb_n_o(), .abb_oe, .artry_n_o(), .artry_oe,
		.shd_n_o(), .shd_oe, .own_addr_req, .own_rd_req, .own_launch, .rd_valid, .rd_data, .snp_req,
		.snp_tt, .lk_valid, .lk_hit_mod, .lk_hit_shr, .wb_req, .wb_done, .to_excl, .tlbie_evt,
		.stale_xlate_pend, .translation_wait_bit);

	bsnp_bus_agent i_agent (.pclk, .ts_oe, .abb_oe, .ts_n, .aack_n, .abb_n, .gbl_n, .tt, .dbb_n,
		.bg_n, .dbg_n, .ta_n, .drtry_n, .hard_reset_pin_n, .dbus);

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// ==========================================================
	// Event counters and timeout
	always @(posedge pclk) begin
		cyc++;
		for (int i = 0; i < 9; i++)
			if (ev[i] === 1'b1) cnt[i]++;
		if (aack_n === 1'b0) t_aack = cyc;
		if (artry_oe === 1'b1) t_art = cyc;
		if (ta_n === 1'b0 && t_ta < 0) t_ta = cyc;
		if (rd_valid === 1'b1) begin
			if (t_rv < 0) t_rv = cyc;
			t_rvl = cyc;
			rdq.push_back(rd_data);
		end
		if (cyc == 5000) begin
			error_cnt++;
			end_of_test();
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic clr();
		foreach (cnt[i]) cnt[i] = 0;
		t_ta = -1;
		t_rv = -1;
		rdq.delete();
	endtask : clr

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdat,
		output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Lookup bits: {wait, stale, valid, modified, shared}; event bits: {tlbie, excl, wb, shd, retry, snoop}
	task automatic snp_chk(input logic g, input logic [4:0] t, input int dly, input logic [4:0] lk,
		input logic [5:0] exp);
		@(posedge pclk);
		{translation_wait_bit, stale_xlate_pend, lk_valid, lk_hit_mod, lk_hit_shr} <= lk;
		clr();
		i_agent.snoop(g, t, dly);
		repeat (8) @(posedge pclk);
		@(negedge pclk);
		for (int i = 0; i < 6; i++) chk(32'(cnt[i]), 32'(exp[i]));
		if (exp[1]) chk(32'(t_art - t_aack), 32'h0000_0003);
		if (exp[0]) chk(32'(snp_tt), 32'(t));
	endtask : snp_chk

	task automatic data_run(input int n, input logic [31:0] base, input int kill, input int nexp,
		input int skip, input int lat);
		clr();
		i_agent.burst(n, base, kill);
		repeat (8) @(posedge pclk);
		@(negedge pclk);
		chk(32'(rdq.size()), 32'(nexp));
		for (int i = 0; i < nexp; i++) chk(rdq[i], base + 32'(i) + 32'(skip >= 0 && i >= skip));
		if (nexp > 0) chk(32'(t_rv - t_ta), 32'(lat));
	endtask : data_run

	// ==========================================================
	// Scenarios
	task automatic t_regs();
		apb(1'b0, BSNP_CTRL_OFF, '0, rd, er);
		chk(rd, 32'h0000_0001);
		apb(1'b1, BSNP_STATUS_OFF, 32'hffff_ffff, rd, er);
		apb(1'b0, BSNP_STATUS_OFF, '0, rd, er);
		chk(rd, 32'h0000_0000);
		apb(1'b0, 8'h0c, '0, rd, er);
		chk(rd, 32'h0000_0000);
		chk(32'(er), 32'h0000_0001);
		$display("t_regs done");
	endtask : t_regs

	task automatic t_snoop();
		apb(1'b1, BSNP_RETRY_OFF, '0, rd, er);
		snp_chk(1'b0, 5'h00, 1, 5'h04, 6'h00);
		snp_chk(1'b1, 5'h00, 6, 5'h04, 6'h01);
		apb(1'b1, BSNP_CTRL_OFF, '0, rd, er);
		snp_chk(1'b1, 5'h00, 1, 5'h04, 6'h00);
		apb(1'b1, BSNP_CTRL_OFF, 32'h0000_0001, rd, er);
		snp_chk(1'b1, 5'h00, 1, 5'h06, 6'h0f);
		snp_chk(1'b1, 5'h00, 6, 5'h04, 6'h03);
		snp_chk(1'b1, BSNP_TT_SYNC, 1, 5'h04, 6'h03);
		snp_chk(1'b1, BSNP_TT_EIEIO, 1, 5'h04, 6'h01);
		@(posedge pclk);
		wb_done <= 1'b1;
		@(posedge pclk);
		wb_done <= 1'b0;
		snp_chk(1'b1, 5'h00, 1, 5'h04, 6'h01);
		snp_chk(1'b1, BSNP_TT_RWNITC, 6, 5'h05, 6'h15);
		snp_chk(1'b1, 5'h00, 1, 5'h00, 6'h03);
		snp_chk(1'b1, BSNP_TT_TLBSYNC, 1, 5'h0c, 6'h03);
		snp_chk(1'b1, BSNP_TT_TLBSYNC, 6, 5'h04, 6'h01);
		snp_chk(1'b1, BSNP_TT_TLBIE, 1, 5'h14, 6'h03);
		snp_chk(1'b1, BSNP_TT_TLBIE, 1, 5'h04, 6'h21);
		apb(1'b0, BSNP_RETRY_OFF, '0, rd, er);
		chk(rd, 32'h0000_0006);
		$display("t_snoop done");
	endtask : t_snoop

	task automatic t_own();
		clr();
		@(posedge pclk);
		i_agent.m_abb_n <= 1'b0;
		i_agent.gbl_n <= 1'b0;
		repeat (3) @(posedge pclk);
		own_addr_req <= 1'b1;
		repeat (10) @(posedge pclk);
		chk(32'(cnt[7]), 32'h0000_0000);
		i_agent.m_abb_n <= 1'b1;
		for (int i = 0; i < 20 && own_launch !== 1'b1; i++) @(posedge pclk);
		own_addr_req <= 1'b0;
		repeat (12) @(posedge pclk);
		i_agent.gbl_n <= 1'b1;
		@(negedge pclk);
		chk(32'(cnt[7]), 32'h0000_0001);
		chk(32'(cnt[8] >= 2), 32'h0000_0001);
		chk(32'(cnt[0] + cnt[1]), 32'h0000_0000);
		chk(32'(abb_oe), 32'h0000_0000);
		$display("t_own done");
	endtask : t_own

	task automatic t_data();
		@(posedge pclk);
		own_rd_req <= 1'b1;
		data_run(1, 32'h1000_0000, 99, 4, -1, 4);
		data_run(1, 32'h2000_0000, 1, 4, 1, 4);
		@(posedge pclk);
		i_agent.dbb_n <= 1'b0;
		data_run(1, 32'h3000_0000, 99, 0, -1, 0);
		@(posedge pclk);
		i_agent.dbb_n <= 1'b1;
		presetn <= 1'b0;
		i_agent.hard_reset_pin_n <= 1'b0;
		i_agent.drtry_n <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		i_agent.hard_reset_pin_n <= 1'b1;
		i_agent.drtry_n <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(1'b0, BSNP_STATUS_OFF, '0, rd, er);
		chk(rd & 32'h0000_0003, 32'h0000_0003);
		data_run(2, 32'h4000_0000, 99, 8, -1, 3);
		chk(32'(t_rvl - t_rv), 32'h0000_0007);
		$display("t_data done");
	endtask : t_data

	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_of_test

	initial begin
		{presetn, psel, penable, pwrite, own_addr_req, own_rd_req, lk_hit_mod, lk_hit_shr} = '0;
		{wb_done, stale_xlate_pend, translation_wait_bit} = '0;
		lk_valid = 1'b1;
		paddr = '0;
		pwdata = '0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_snoop();
		t_own();
		t_data();
		end_of_test();
	end

endmodule : tb
